/* File: logic/hbg_pkg.sv */
// constants and types shared by the half-bridge gate sequencer
package hbg_pkg;
  // apb register byte offsets
  localparam logic [7:0] HBG_OFS_CTRL = 8'h00;
  localparam logic [7:0] HBG_OFS_MAXF = 8'h04;
  localparam logic [7:0] HBG_OFS_DEAD = 8'h08;
  localparam logic [7:0] HBG_OFS_STAT = 8'h0c;
  localparam logic [7:0] HBG_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] HBG_OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] HBG_OFS_IRQ_EN = 8'h18;
  // reset values
  localparam logic HBG_RST_ENABLE = 1'b1;
  localparam logic [7:0] HBG_RST_MAXF = 8'hc8;
  localparam logic [7:0] HBG_RST_DEAD = 8'h14;
  localparam logic [4:0] HBG_RST_IRQ_EN = 5'h00;
  // event bit positions
  localparam int HBG_EV_FAST = 0;
  localparam int HBG_EV_SLOW = 1;
  localparam int HBG_EV_BLANK = 2;
  localparam int HBG_EV_BULK = 3;
  localparam int HBG_EV_LOCK = 4;
  localparam int HBG_NUM_EV = 5;
  // oscillator: half period in cycles = base - 4 * feedback code
  localparam logic [10:0] HBG_HALF_BASE = 11'h44c;
  // slow overcurrent: consecutive periods before trip
  localparam logic [3:0] HBG_SLOW_LIMIT = 4'h8;
  // timing
  localparam int HBG_CLK_NS = 5;
  localparam int HBG_SS_STEP_NS = 1000;
  localparam int HBG_FAULT_HOLD_NS = 100000;
  localparam int HBG_SS_STEP_CYC = (HBG_SS_STEP_NS + HBG_CLK_NS - 1) / HBG_CLK_NS;
  localparam int HBG_FAULT_HOLD_CYC = (HBG_FAULT_HOLD_NS + HBG_CLK_NS - 1) / HBG_CLK_NS;
  typedef enum logic [4:0] {
    HBG_ST_LOCK = 5'h01,
    HBG_ST_BOOST = 5'h02,
    HBG_ST_SOFT = 5'h04,
    HBG_ST_RUN = 5'h08,
    HBG_ST_FAULT = 5'h10
  } hbg_state_t;
endpackage

/* File: logic/hbg_sequencer.sv */
// half-bridge gate sequencer with apb registers and interrupt
`timescale 1ns/100ps
module hbg_sequencer
  import hbg_pkg::*;
#(
  parameter int FAULT_HOLD_CYC = hbg_pkg::HBG_FAULT_HOLD_CYC
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // analog front end, asynchronous
  input wire logic [7:0] freq_feedback_pin,
  input wire logic supply_lockout,
  input wire logic bridge_start_level,
  input wire logic bridge_stop_level,
  input wire logic fast_trip_level,
  input wire logic slow_trip_level,
  // drives
  output logic high_side_drive,
  output logic low_side_drive,
  output logic boost_drive,
  output logic soft_start_pullup,
  output logic soft_start_discharge
);
  import hbg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  // the feedback code is a word: it is taken only when two samples agree
  logic [7:0] fb_last;
  logic [7:0] fb_code;
  wire [NSYNC-1:0] raw_in = {freq_feedback_pin, supply_lockout, bridge_start_level,
    bridge_stop_level, fast_trip_level, slow_trip_level};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
      fb_last <= '0;
      fb_code <= '0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      fb_last <= sync_b[12:5];
      if (fb_last == sync_b[12:5])
        fb_code <= fb_last;
    end
  end
  wire lock_s = sync_b[4];
  wire start_s = sync_b[3];
  wire stop_s = sync_b[2];
  wire fast_s = sync_b[1];
  wire slow_s = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic enable;
  logic [7:0] max_code;
  logic [7:0] dead_cyc;
  logic [4:0] irq_stat;
  logic [4:0] irq_en;
  hbg_state_t state;
  hbg_state_t next_state;
  logic [10:0] ph_cnt;
  logic phase;
  logic blank;
  logic [7:0] ss_level;
  logic [7:0] ss_tick;
  logic [3:0] slow_cnt;
  logic slow_seen;
  logic [31:0] hold_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and gate timing
  // soft start holds the code at its ramp level until the loop takes over
  wire ss_on = (state == HBG_ST_SOFT);
  wire [7:0] eff_code = (ss_on && ss_level > fb_code) ? ss_level : fb_code;
  wire [10:0] half_len = HBG_HALF_BASE - {1'b0, eff_code, 2'b00};
  wire half_end = (ph_cnt >= half_len - 11'h001);
  wire period_end = half_end && phase;
  wire bridge_live = (state == HBG_ST_SOFT) || (state == HBG_ST_RUN);
  // next-state gating stops drives at once on shutdown but keeps soft to run seamless
  wire next_live = (next_state == HBG_ST_SOFT) || (next_state == HBG_ST_RUN);
  wire past_dead = (ph_cnt >= {3'h0, dead_cyc});
  wire gate_ok = bridge_live && !blank && past_dead && !fast_s;
  wire next_high = gate_ok && !phase;
  wire next_low = gate_ok && phase;
  // boost runs in the high-side half whenever supply is good, sharing the same dead interval
  wire next_boost = (state != HBG_ST_LOCK) && !lock_s && !phase && past_dead;
  wire blank_now = (eff_code >= max_code);

  ////////////////////////////////////////////////////////////////////////////
  // shutdown causes
  wire slow_trip = period_end && (slow_seen || slow_s) &&
    (slow_cnt == HBG_SLOW_LIMIT - 4'h1);
  wire bulk_low = bridge_live && !stop_s;
  wire fast_trip = bridge_live && fast_s;
  wire hold_done = (hold_cnt >= FAULT_HOLD_CYC - 1);

  always_comb
  begin
    next_state = state;
    case (state)
      HBG_ST_LOCK: next_state = HBG_ST_BOOST;
      HBG_ST_BOOST: if (start_s && enable) next_state = HBG_ST_SOFT;
      HBG_ST_SOFT: if (ss_level == 8'h00) next_state = HBG_ST_RUN;
      HBG_ST_RUN: next_state = HBG_ST_RUN;
      HBG_ST_FAULT: if (hold_done) next_state = HBG_ST_BOOST;
      default: next_state = HBG_ST_LOCK;
    endcase
    if (bridge_live && (fast_trip || slow_trip || bulk_low || !enable))
      next_state = HBG_ST_FAULT;
    if (lock_s)
      next_state = HBG_ST_LOCK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= HBG_ST_LOCK;
    else
      state <= next_state;
  end

  // period counter; blanking latched only at a period boundary so no pulse is cut
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_cnt <= '0;
      phase <= 1'b0;
      blank <= 1'b1;
    end
    else if (half_end)
    begin
      ph_cnt <= '0;
      phase <= !phase;
      if (phase)
        blank <= blank_now;
    end
    else
      ph_cnt <= ph_cnt + 11'h001;
  end

  // slow overcurrent period counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_cnt <= '0;
      slow_seen <= 1'b0;
    end
    else if (!bridge_live)
    begin
      slow_cnt <= '0;
      slow_seen <= 1'b0;
    end
    else if (period_end)
    begin
      slow_cnt <= (slow_seen || slow_s) ? slow_cnt + 4'h1 : 4'h0;
      slow_seen <= 1'b0;
    end
    else if (slow_s)
      slow_seen <= 1'b1;
  end

  // soft-start ramp and fault hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ss_level <= '0;
      ss_tick <= '0;
      hold_cnt <= '0;
    end
    else
    begin
      hold_cnt <= (state == HBG_ST_FAULT) ? hold_cnt + 32'h1 : 32'h0;
      if (state != HBG_ST_SOFT)
      begin
        ss_level <= max_code - 8'h01;
        ss_tick <= '0;
      end
      else if (ss_tick >= 8'(HBG_SS_STEP_CYC - 1))
      begin
        ss_tick <= '0;
        ss_level <= ss_level - 8'h01;
      end
      else
        ss_tick <= ss_tick + 8'h01;
    end
  end

  // output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      boost_drive <= 1'b0;
      soft_start_pullup <= 1'b0;
      soft_start_discharge <= 1'b1;
    end
    else
    begin
      high_side_drive <= next_high && next_live;
      low_side_drive <= next_low && next_live;
      boost_drive <= next_boost && !lock_s;
      soft_start_pullup <= (next_state == HBG_ST_SOFT);
      soft_start_discharge <= !(next_state == HBG_ST_SOFT || next_state == HBG_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase
  wire setup = psel && !penable;
  wire hit_ctrl = (paddr == HBG_OFS_CTRL);
  wire hit_maxf = (paddr == HBG_OFS_MAXF);
  wire hit_dead = (paddr == HBG_OFS_DEAD);
  wire hit_stat = (paddr == HBG_OFS_STAT);
  wire hit_ist = (paddr == HBG_OFS_IRQ_STAT);
  wire hit_iclr = (paddr == HBG_OFS_IRQ_CLR);
  wire hit_ien = (paddr == HBG_OFS_IRQ_EN);
  wire mapped = hit_ctrl | hit_maxf | hit_dead | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire wr = psel && penable && pready && pwrite && !pslverr;
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, enable} :
    hit_maxf ? {24'h0, max_code} :
    hit_dead ? {24'h0, dead_cyc} :
    hit_stat ? {18'h0, slow_cnt, blank, phase, 3'h0, state} :
    hit_ist ? {27'h0, irq_stat} :
    hit_ien ? {27'h0, irq_en} : 32'h0;
  wire [4:0] events = {(state != HBG_ST_LOCK) && lock_s, bulk_low,
    bridge_live && half_end && phase && blank_now, slow_trip, fast_trip};
  wire [4:0] clr = (wr && hit_iclr) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable <= HBG_RST_ENABLE;
      max_code <= HBG_RST_MAXF;
      dead_cyc <= HBG_RST_DEAD;
      irq_en <= HBG_RST_IRQ_EN;
      irq_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
        enable <= pwdata[0];
      if (wr && hit_maxf)
        max_code <= pwdata[7:0];
      if (wr && hit_dead)
        dead_cyc <= pwdata[7:0];
      if (wr && hit_ien)
        irq_en <= pwdata[4:0];
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~clr) | events;
      irq <= |(((irq_stat & ~clr) | events) & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_NO_OVERLAP: assert property (@(posedge pclk) disable iff (!presetn)
    !(high_side_drive && low_side_drive))
    else $error("both gates on");
  AST_DEAD_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(high_side_drive) |-> !low_side_drive [*2])
    else $error("no dead gap after high side");
  AST_HIGH_IN_PHASE0: assert property (@(posedge pclk) disable iff (!presetn)
    high_side_drive |-> $past(!phase))
    else $error("high side outside its half");
  AST_BLANK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    blank |=> !high_side_drive && !low_side_drive)
    else $error("gates on while blanked");
  AST_BLANK_BOUNDARY: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(blank) |-> $past(period_end))
    else $error("blank changed mid period");
  AST_FAST_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    fast_trip |=> state == HBG_ST_FAULT || state == HBG_ST_LOCK)
    else $error("fast trip ignored");
  AST_SLOW_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    slow_trip && !lock_s |=> state == HBG_ST_FAULT)
    else $error("slow trip ignored");
  AST_SLOW_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !bridge_live |=> slow_cnt == 4'h0)
    else $error("slow count kept in shutdown");
  AST_LOCK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    lock_s |=> !high_side_drive && !low_side_drive && !boost_drive)
    else $error("drive during lockout");
  AST_BOOST_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    state == HBG_ST_BOOST |=> !high_side_drive && !low_side_drive)
    else $error("bridge on before start");
  AST_SOFT_START: assert property (@(posedge pclk) disable iff (!presetn)
    state == HBG_ST_BOOST && start_s && enable && !lock_s |=> ##[0:1] soft_start_pullup)
    else $error("soft start not entered");
  AST_BULK_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    bulk_low && !lock_s |=> state == HBG_ST_FAULT ##1 soft_start_discharge)
    else $error("bulk low ignored");
  AST_SS_DECAY: assert property (@(posedge pclk) disable iff (!presetn)
    ss_on && $past(ss_on) |-> ss_level <= $past(ss_level))
    else $error("soft start level rose");
  AST_DEAD_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
    (high_side_drive || boost_drive) |-> $past(ph_cnt) >= {3'h0, $past(dead_cyc)})
    else $error("dead time violated");
  AST_FREQ_UP: assert property (@(posedge pclk) disable iff (!presetn)
    eff_code > $past(eff_code) |-> half_len < $past(half_len))
    else $error("frequency did not rise");
  COV_RUN: cover property (@(posedge pclk) disable iff (!presetn) state == HBG_ST_RUN);
  COV_FAST: cover property (@(posedge pclk) disable iff (!presetn) fast_trip);
  COV_SLOW: cover property (@(posedge pclk) disable iff (!presetn) slow_trip);
  COV_BLANK: cover property (@(posedge pclk) disable iff (!presetn) bridge_live && blank);
endmodule

/* File: sim/hbg_gate_model.sv */
// gate driver model: watches the two bridge drives and measures each on pulse
`timescale 1ns/100ps
module hbg_gate_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drives from the sequencer
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  // last on-time of each side and a sticky overlap flag
  output logic [15:0] high_on_len,
  output logic [15:0] low_on_len,
  output logic overlap
);
  logic [15:0] high_run;
  logic [15:0] low_run;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_run <= 16'h0000;
      low_run <= 16'h0000;
      high_on_len <= 16'h0000;
      low_on_len <= 16'h0000;
      overlap <= 1'b0;
    end
    else
    begin
      // both switches on at once would short the bulk rail
      overlap <= overlap | (high_side_drive & low_side_drive);
      high_run <= high_side_drive ? high_run + 16'h0001 : 16'h0000;
      low_run <= low_side_drive ? low_run + 16'h0001 : 16'h0000;
      // a pulse length is latched only when it ends, so a cut pulse shows up
      if (!high_side_drive && high_run != 16'h0000)
        high_on_len <= high_run;
      if (!low_side_drive && low_run != 16'h0000)
        low_on_len <= low_run;
    end
  end
endmodule

/* File: sim/hbg_sequencer_tb.sv */
// self-checking bench for the half-bridge gate sequencer
`timescale 1ns/100ps
module hbg_sequencer_tb;
  import hbg_pkg::*;
  typedef struct packed
    {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} hbg_row_t;
  logic pclk, pready, pslverr, irq, hs, ls, bst, pull, dis, ovl, e, act, prev;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lock = 1'b0, start = 1'b0, stop = 1'b1, fast = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00, fb = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] hlen, llen;
  int err_total, checks, i, n;
  hbg_row_t rows [12];
  //////////////////////////////////////////////////////////////////////////////
  hbg_sequencer #(.FAULT_HOLD_CYC(200)) dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .freq_feedback_pin(fb), .supply_lockout(lock), .bridge_start_level(start),
    .bridge_stop_level(stop), .fast_trip_level(fast), .slow_trip_level(slow),
    .high_side_drive(hs), .low_side_drive(ls), .boost_drive(bst),
    .soft_start_pullup(pull), .soft_start_discharge(dis)
  );
  hbg_gate_model gate_u
  (
    .pclk(pclk), .presetn(presetn), .high_side_drive(hs), .low_side_drive(ls),
    .high_on_len(hlen), .low_on_len(llen), .overlap(ovl)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(pready), 32'h1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic wait_st(input logic [4:0] s);
    n = 0;
    q = 32'h0;
    while (q[4:0] !== s && n < 3000)
    begin
      apb(1'b0, HBG_OFS_STAT, 32'h0);
      n++;
    end
    chk(32'(q[4:0]), 32'(s));
  endtask
  task automatic print_verdict;
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
  initial
  begin
    rows = '{'{1'b0, HBG_OFS_CTRL, 32'h0, 32'h1, 1'b0},
      '{1'b0, HBG_OFS_MAXF, 32'h0, 32'hc8, 1'b0}, '{1'b0, HBG_OFS_DEAD, 32'h0, 32'h14, 1'b0},
      '{1'b0, HBG_OFS_IRQ_EN, 32'h0, 32'h0, 1'b0}, '{1'b0, HBG_OFS_IRQ_STAT, 32'h0, 32'h0, 1'b0},
      '{1'b0, HBG_OFS_IRQ_CLR, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h1c, 32'hff, 32'h0, 1'b1}, '{1'b1, HBG_OFS_DEAD, 32'h4, 32'h0, 1'b0},
      '{1'b0, HBG_OFS_DEAD, 32'h0, 32'h4, 1'b0}, '{1'b1, HBG_OFS_IRQ_EN, 32'h1f, 32'h0, 1'b0},
      '{1'b1, HBG_OFS_MAXF, 32'h10, 32'h0, 1'b0}};
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      if (!rows[i].w)
        chk(q, rows[i].x);
    end
    // boost alone before the bulk is up
    wait_st(5'h02);
    n = 0;
    act = 1'b0;
    prev = 1'b0;
    repeat (2400)
    begin
      @(negedge pclk);
      if (bst && !prev)
        n++;
      prev = bst;
      act = act | hs | ls;
    end
    chk(32'(n > 0), 32'h1);
    chk(32'(act), 32'h0);
    chk(32'(dis), 32'h1);
    @(posedge pclk);
    start <= 1'b1;
    cyc(8);
    chk(32'(pull), 32'h1);
    chk(32'(dis), 32'h0);
    wait_st(5'h04);
    cyc(2300);
    chk(32'(hlen != 16'h0000 && hlen < 16'h0448), 32'h1);
    wait_st(5'h08);
    cyc(4500);
    chk(32'(hlen), 32'h448);
    chk(32'(llen), 32'h448);
    chk(32'(pull), 32'h0);
    apb(1'b1, HBG_OFS_MAXF, 32'hff);
    fb <= 8'hf0;
    cyc(3000);
    chk(32'(hlen), 32'h88);
    chk(32'(llen), 32'h88);
    // commanded code above the limit blanks whole periods
    apb(1'b1, HBG_OFS_MAXF, 32'h80);
    cyc(600);
    act = 1'b0;
    repeat (560)
    begin
      @(negedge pclk);
      act = act | hs | ls;
    end
    chk(32'(act), 32'h0);
    chk(32'(hlen), 32'h88);
    chk(32'(llen), 32'h88);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q & 32'h4, 32'h4);
    cyc(1);
    chk(32'(irq), 32'h1);
    apb(1'b1, HBG_OFS_MAXF, 32'hff);
    cyc(600);
    apb(1'b1, HBG_OFS_IRQ_CLR, 32'h4);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    cyc(1);
    chk(32'(irq), 32'h0);
    // slow trip is masked from the interrupt line
    apb(1'b1, HBG_OFS_IRQ_EN, 32'h1d);
    slow <= 1'b1;
    cyc(1500);
    apb(1'b0, HBG_OFS_STAT, 32'h0);
    chk(32'(q[4:0]), 32'h8);
    chk(32'(q[13:10] != 4'h0), 32'h1);
    wait_st(5'h10);
    apb(1'b0, HBG_OFS_STAT, 32'h0);
    chk(32'(q[13:10]), 32'h0);
    chk(32'({hs, ls, dis}), 32'h1);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    cyc(1);
    chk(32'(irq), 32'h0);
    // slow ramp restart: small limit and idle feedback before the hold ends
    @(posedge pclk);
    slow <= 1'b0;
    fb <= 8'h00;
    apb(1'b1, HBG_OFS_MAXF, 32'h10);
    apb(1'b1, HBG_OFS_IRQ_CLR, 32'h1f);
    apb(1'b1, HBG_OFS_IRQ_EN, 32'h1f);
    wait_st(5'h04);
    chk(32'(pull), 32'h1);
    wait_st(5'h08);
    fast <= 1'b1;
    cyc(6);
    chk(32'({hs, ls}), 32'h0);
    wait_st(5'h10);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    cyc(1);
    chk(32'(irq), 32'h1);
    @(posedge pclk);
    fast <= 1'b0;
    wait_st(5'h04);
    stop <= 1'b0;
    cyc(6);
    chk(32'({hs, ls, pull}), 32'h0);
    wait_st(5'h10);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q & 32'h8, 32'h8);
    stop <= 1'b1;
    wait_st(5'h04);
    // clearing the enable faults the bridge and holds it back until set again
    apb(1'b1, HBG_OFS_CTRL, 32'h0);
    wait_st(5'h10);
    wait_st(5'h02);
    cyc(300);
    chk(32'({hs, ls, pull, dis}), 32'h1);
    apb(1'b1, HBG_OFS_CTRL, 32'h1);
    wait_st(5'h04);
    lock <= 1'b1;
    cyc(6);
    chk(32'({hs, ls, bst, pull}), 32'h0);
    wait_st(5'h01);
    apb(1'b0, HBG_OFS_IRQ_STAT, 32'h0);
    chk(q & 32'h10, 32'h10);
    chk(32'(ovl), 32'h0);
    lock <= 1'b0;
    wait_st(5'h04);
    presetn <= 1'b0;
    cyc(3);
    chk(32'({hs, ls, bst, pull, irq, dis}), 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, HBG_OFS_STAT, 32'h0);
    chk(32'(q[4:0]), 32'h2);
    print_verdict;
  end
endmodule
